// >>> sle_defs.svh
/*
 * Timing, count and code constants of the status LED blink encoder.
 * Assumes inclusion by bare name from the top design module only.
 */
`ifndef SLE_DEFS_SVH
`define SLE_DEFS_SVH

// Clock and tick
`define SLE_CLK_HZ        25000000
`define SLE_TICK_MS       1

// Blink phase times in milliseconds
`define SLE_FAST_MS       16'h0032
`define SLE_FLASH_MS      16'h00C8
`define SLE_PAUSE_MS      16'h03E8

// Flash counts of the bus error patterns
`define SLE_N_WARN        4'h1
`define SLE_N_GUARD       4'h2
`define SLE_N_SYNC        4'h3
`define SLE_N_EVENT       4'h4
`define SLE_N_ONE         4'h1

// Fast blinks that open a local fault report
`define SLE_N_BURST       4'h8

// Local fault codes
`define SLE_CODE_BREAK    4'h3
`define SLE_CODE_BADMSG   4'h4

// Watchdog slots
`define SLE_WD_GUARD      0
`define SLE_WD_HBEAT      1
`define SLE_WD_SYNC       2
`define SLE_WD_EVENT      3
`define SLE_WD_NUM        4

`endif

// >>> sle_pkg.sv
/*
 * Types of the status LED blink encoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sle_pkg;

   // Node state reported by the protocol engine
   typedef enum logic [1:0] {
      SLE_NMT_STOPPED = 2'h0,
      SLE_NMT_PREOP   = 2'h1,
      SLE_NMT_OP      = 2'h2
   } sle_nmt_t;

   // Pattern shown on the bus error indicator
   typedef enum logic [5:0] {
      SLE_BP_OFF   = 6'b00_0001,
      SLE_BP_FAST  = 6'b00_0010,
      SLE_BP_WARN  = 6'b00_0100,
      SLE_BP_GUARD = 6'b00_1000,
      SLE_BP_SYNC  = 6'b01_0000,
      SLE_BP_EVENT = 6'b10_0000
   } sle_bus_pat_t;

   // Pattern shown on the node state indicator
   typedef enum logic [4:0] {
      SLE_NP_DARK  = 5'b0_0001,
      SLE_NP_FAST  = 5'b0_0010,
      SLE_NP_FLASH = 5'b0_0100,
      SLE_NP_BLINK = 5'b0_1000,
      SLE_NP_ON    = 5'b1_0000
   } sle_node_pat_t;

   // Local fault report sequencer
   typedef enum logic [3:0] {
      SLE_LS_IDLE  = 4'b0001,
      SLE_LS_BURST = 4'b0010,
      SLE_LS_CODE  = 4'b0100,
      SLE_LS_ARG   = 4'b1000
   } sle_loc_st_t;

endpackage

// >>> sle_blinker.sv
/*
 * Flash group generator: flash_n flashes of on_ms lit and off_ms dark,
 * the last dark phase stretched to pause_ms, repeating.
 * Assumes a one-cycle millisecond tick on the same clock.
 */
`timescale 1ns/10ps

module sle_blinker #(
   parameter int CW = 16
) (
   input  wire logic          ref_clk,    // System clock
   input  wire logic          srst,       // Sync reset, high
   input  wire logic          ms_tick,    // Millisecond enable
   input  wire logic          restart,    // Start over at first flash
   input  wire logic [3:0]    flash_n,    // Flashes per group
   input  wire logic [CW-1:0] on_ms,      // Lit time
   input  wire logic [CW-1:0] off_ms,     // Dark time between flashes
   input  wire logic [CW-1:0] pause_ms,   // Dark time after group
   output logic               led_on,     // Lit phase
   output logic               cycle_done  // Group finished, pulse
);

   logic          lit_ff;
   logic [CW-1:0] cnt_ff;
   logic [3:0]    idx_ff;
   logic          last;
   logic [CW-1:0] dark_lim;

   assign last     = (idx_ff >= flash_n);
   assign dark_lim = last ? pause_ms : off_ms;
   assign led_on   = lit_ff;
   assign cycle_done = ms_tick & ~lit_ff & last
                       & (cnt_ff >= dark_lim - CW'(1));

   always_ff @(posedge ref_clk) begin
      if (srst || restart) begin
         lit_ff <= 1'b1;
         cnt_ff <= '0;
         idx_ff <= 4'h1;
      end else if (ms_tick) begin
         if (lit_ff) begin
            if (cnt_ff >= on_ms - CW'(1)) begin
               lit_ff <= 1'b0;
               cnt_ff <= '0;
            end else begin
               cnt_ff <= cnt_ff + CW'(1);
            end
         end else if (cnt_ff >= dark_lim - CW'(1)) begin
            lit_ff <= 1'b1;
            cnt_ff <= '0;
            idx_ff <= last ? 4'h1 : idx_ff + 4'h1;
         end else begin
            cnt_ff <= cnt_ff + CW'(1);
         end
      end
   end

endmodule // sle_blinker

// >>> sle_status_led.sv
/*
 * Status LED blink encoder: bus error, node state, local I/O ok and
 * local I/O fault indicators, plus the supervision watchdogs whose
 * failures drive the node to pre-operational with outputs in error.
 * Assumes all status inputs come from logic on ref_clk; *_rx inputs
 * are one-cycle pulses. The supply indicators are not handled here.
 */
`timescale 1ns/10ps
`include "sle_defs.svh"

module sle_status_led #(
   parameter int MS_TICK_CYC = `SLE_CLK_HZ / (1000 / `SLE_TICK_MS),
   parameter int TW          = 24
) (
   input  wire logic        ref_clk,       // 25 MHz system clock
   input  wire logic        srst,          // Sync reset, high
   input  wire logic        baud_search,   // Baud rate not yet found
   input  wire logic        can_warn,      // Error warning limit passed
   input  wire logic [1:0]  nmt_state,     // Node state, sle_nmt_t
   input  wire logic        fw_pre_c0,     // Firmware older than C0
   input  wire logic [15:0] guard_ms,      // Guard time
   input  wire logic [7:0]  life_factor,   // Life time factor
   input  wire logic [15:0] hb_cons_ms,    // Consumer heartbeat time
   input  wire logic [15:0] sync_per_ms,   // Communication cycle period
   input  wire logic [15:0] event_ms,      // RxPDO event time
   input  wire logic        guard_rx,      // Guard message seen, pulse
   input  wire logic        hb_rx,         // Heartbeat seen, pulse
   input  wire logic        sync_rx,       // Sync seen, pulse
   input  wire logic        rpdo_rx,       // RxPDO seen, pulse
   input  wire logic        err_clr,       // Clear latched errors, pulse
   input  wire logic        io_link_up,    // Local link exchanging data
   input  wire logic        io_fault,      // Other local fault
   input  wire logic [3:0]  io_code,       // Code of other local fault
   input  wire logic [3:0]  io_arg,        // Argument of that fault
   input  wire logic        link_break,    // Link break located
   input  wire logic [3:0]  break_pos,     // Module before the receiver
   input  wire logic        bad_msgs,      // Too many faulty messages
   input  wire logic [3:0]  bad_pos,       // Module where they arise
   output logic             bus_err_led,   // Bus error LED, registered
   output logic             node_led,      // Node state LED, registered
   output logic             io_ok_led,     // Local ok LED, registered
   output logic             io_fault_led,  // Local fault LED, registered
   output logic             force_preop,   // Supervision error held
   output logic             pdo_stop,      // PDOs switched off
   output logic             outputs_err,   // Outputs to error values
   output logic             sdo_pdo_rej,   // SDO/PDO refused
   output logic             guard_err,     // Guard or heartbeat lost
   output logic             sync_err,      // Sync lost
   output logic             event_err      // Event timer expired
);

   localparam int DW = $clog2(MS_TICK_CYC);

   ////////////////////////////////////////////////////////////////////
   // Millisecond tick

   logic [DW-1:0] div_ff;
   logic          ms_tick;

   assign ms_tick = (div_ff == DW'(MS_TICK_CYC - 1));

   always_ff @(posedge ref_clk) begin
      if (srst || ms_tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + DW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Supervision watchdogs

   logic [TW-1:0] wd_lim  [`SLE_WD_NUM];
   logic          wd_en   [`SLE_WD_NUM];
   logic          wd_kick [`SLE_WD_NUM];
   logic          wd_err_ff [`SLE_WD_NUM];
   logic [TW-1:0] wd_cnt_ff [`SLE_WD_NUM];

   always_comb begin
      wd_lim[`SLE_WD_GUARD]  = TW'(guard_ms) * TW'(life_factor);
      wd_en[`SLE_WD_GUARD]   = (guard_ms != 16'h0000)
                               && (life_factor != 8'h00);
      wd_kick[`SLE_WD_GUARD] = guard_rx;
      wd_lim[`SLE_WD_HBEAT]  = TW'(hb_cons_ms);
      wd_en[`SLE_WD_HBEAT]   = (hb_cons_ms != 16'h0000);
      wd_kick[`SLE_WD_HBEAT] = hb_rx;
      wd_lim[`SLE_WD_SYNC]   = TW'({1'b0, sync_per_ms}
                               + {2'b00, sync_per_ms[15:1]});
      wd_en[`SLE_WD_SYNC]    = (sync_per_ms != 16'h0000);
      wd_kick[`SLE_WD_SYNC]  = sync_rx;
      wd_lim[`SLE_WD_EVENT]  = TW'(event_ms);
      wd_en[`SLE_WD_EVENT]   = (event_ms != 16'h0000);
      wd_kick[`SLE_WD_EVENT] = rpdo_rx;
   end

   for (genvar i = 0; i < `SLE_WD_NUM; i++) begin : g_wd
      always_ff @(posedge ref_clk) begin
         if (srst || !wd_en[i] || wd_kick[i]) begin
            wd_cnt_ff[i] <= '0;
         end else if (ms_tick && (wd_cnt_ff[i] < wd_lim[i])) begin
            wd_cnt_ff[i] <= wd_cnt_ff[i] + TW'(1);
         end
      end

      // Set wins over clear
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            wd_err_ff[i] <= 1'b0;
         end else if (wd_en[i] && (wd_cnt_ff[i] >= wd_lim[i])) begin
            wd_err_ff[i] <= 1'b1;
         end else if (err_clr) begin
            wd_err_ff[i] <= 1'b0;
         end
      end
   end

   assign guard_err   = wd_err_ff[`SLE_WD_GUARD] | wd_err_ff[`SLE_WD_HBEAT];
   assign sync_err    = wd_err_ff[`SLE_WD_SYNC];
   assign event_err   = wd_err_ff[`SLE_WD_EVENT];
   assign force_preop = guard_err | sync_err | event_err;
   assign pdo_stop    = force_preop
                        | (nmt_state == sle_pkg::SLE_NMT_STOPPED);
   assign outputs_err = force_preop;
   assign sdo_pdo_rej = (nmt_state == sle_pkg::SLE_NMT_STOPPED)
                        && !force_preop;

   ////////////////////////////////////////////////////////////////////
   // Pattern selection

   sle_pkg::sle_bus_pat_t  bus_pat, bus_pat_ff;
   sle_pkg::sle_node_pat_t node_pat, node_pat_ff;

   always_comb begin
      if (baud_search) begin
         bus_pat = sle_pkg::SLE_BP_FAST;
      end else if (event_err) begin
         bus_pat = sle_pkg::SLE_BP_EVENT;
      end else if (sync_err) begin
         bus_pat = sle_pkg::SLE_BP_SYNC;
      end else if (guard_err) begin
         bus_pat = sle_pkg::SLE_BP_GUARD;
      end else if (can_warn) begin
         bus_pat = sle_pkg::SLE_BP_WARN;
      end else begin
         bus_pat = sle_pkg::SLE_BP_OFF;
      end
   end

   always_comb begin
      if (baud_search) begin
         node_pat = sle_pkg::SLE_NP_FAST;
      end else if (force_preop || nmt_state == sle_pkg::SLE_NMT_PREOP) begin
         node_pat = sle_pkg::SLE_NP_BLINK;
      end else if (nmt_state == sle_pkg::SLE_NMT_OP) begin
         node_pat = sle_pkg::SLE_NP_ON;
      end else if (fw_pre_c0) begin
         node_pat = sle_pkg::SLE_NP_DARK;
      end else begin
         node_pat = sle_pkg::SLE_NP_FLASH;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus_pat_ff  <= sle_pkg::SLE_BP_OFF;
         node_pat_ff <= sle_pkg::SLE_NP_DARK;
      end else begin
         bus_pat_ff  <= bus_pat;
         node_pat_ff <= node_pat;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fieldbus indicators

   logic [3:0]  bus_n;
   logic [15:0] bus_on, bus_pause, node_on;
   logic        bus_lit, node_lit;

   always_comb begin
      unique case (bus_pat)
         sle_pkg::SLE_BP_FAST:  bus_n = `SLE_N_ONE;
         sle_pkg::SLE_BP_WARN:  bus_n = `SLE_N_WARN;
         sle_pkg::SLE_BP_GUARD: bus_n = `SLE_N_GUARD;
         sle_pkg::SLE_BP_SYNC:  bus_n = `SLE_N_SYNC;
         sle_pkg::SLE_BP_EVENT: bus_n = `SLE_N_EVENT;
         default:               bus_n = `SLE_N_ONE;
      endcase
      bus_on    = baud_search ? `SLE_FAST_MS : `SLE_FLASH_MS;
      bus_pause = baud_search ? `SLE_FAST_MS : `SLE_PAUSE_MS;
      node_on   = (node_pat == sle_pkg::SLE_NP_FLASH) ? `SLE_PAUSE_MS
                                                      : `SLE_FLASH_MS;
   end

   sle_blinker #(.CW(16)) u_bus_blk (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .ms_tick    (ms_tick),
      .restart    (bus_pat != bus_pat_ff),
      .flash_n    (bus_n),
      .on_ms      (bus_on),
      .off_ms     (bus_on),
      .pause_ms   (bus_pause),
      .led_on     (bus_lit),
      .cycle_done ()
   );

   // Node blinker: single flash group; node_on is its dark time
   sle_blinker #(.CW(16)) u_node_blk (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .ms_tick    (ms_tick),
      .restart    (node_pat != node_pat_ff),
      .flash_n    (`SLE_N_ONE),
      .on_ms      (`SLE_FLASH_MS),
      .off_ms     (node_on),
      .pause_ms   (node_on),
      .led_on     (node_lit),
      .cycle_done ()
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus_err_led <= 1'b0;
         node_led    <= 1'b0;
      end else begin
         bus_err_led <= (bus_pat != sle_pkg::SLE_BP_OFF) && bus_lit;
         unique case (node_pat)
            sle_pkg::SLE_NP_DARK:  node_led <= 1'b0;
            sle_pkg::SLE_NP_FAST:  node_led <= !bus_lit;
            sle_pkg::SLE_NP_ON:    node_led <= 1'b1;
            default:               node_led <= node_lit;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Local I/O indicators

   logic                 loc_fault;
   logic [3:0]           loc_code, loc_arg;
   logic [3:0]           loc_n;
   logic [15:0]          loc_on;
   logic                 loc_lit, loc_done;
   sle_pkg::sle_loc_st_t loc_st_ff, nxt_loc_st;

   always_comb begin
      if (link_break) begin
         loc_code = `SLE_CODE_BREAK;
         loc_arg  = break_pos;
      end else if (bad_msgs) begin
         loc_code = `SLE_CODE_BADMSG;
         loc_arg  = bad_pos;
      end else begin
         loc_code = io_code;
         loc_arg  = io_arg;
      end
   end

   assign loc_fault = link_break | bad_msgs | io_fault;

   always_comb begin
      nxt_loc_st = loc_st_ff;
      if (!loc_fault) begin
         nxt_loc_st = sle_pkg::SLE_LS_IDLE;
      end else begin
         unique case (loc_st_ff)
            sle_pkg::SLE_LS_IDLE:  nxt_loc_st = sle_pkg::SLE_LS_BURST;
            sle_pkg::SLE_LS_BURST: if (loc_done) begin
               nxt_loc_st = sle_pkg::SLE_LS_CODE;
            end
            sle_pkg::SLE_LS_CODE:  if (loc_done) begin
               nxt_loc_st = (loc_arg == 4'h0) ? sle_pkg::SLE_LS_BURST
                                              : sle_pkg::SLE_LS_ARG;
            end
            sle_pkg::SLE_LS_ARG:   if (loc_done) begin
               nxt_loc_st = sle_pkg::SLE_LS_BURST;
            end
            default:               nxt_loc_st = sle_pkg::SLE_LS_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         loc_st_ff <= sle_pkg::SLE_LS_IDLE;
      end else begin
         loc_st_ff <= nxt_loc_st;
      end
   end

   always_comb begin
      unique case (loc_st_ff)
         sle_pkg::SLE_LS_BURST: loc_n = `SLE_N_BURST;
         sle_pkg::SLE_LS_CODE:  loc_n = loc_code;
         sle_pkg::SLE_LS_ARG:   loc_n = loc_arg;
         default:               loc_n = `SLE_N_ONE;
      endcase
      loc_on = (loc_st_ff == sle_pkg::SLE_LS_BURST) ? `SLE_FAST_MS
                                                    : `SLE_FLASH_MS;
   end

   sle_blinker #(.CW(16)) u_loc_blk (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .ms_tick    (ms_tick),
      .restart    (nxt_loc_st != loc_st_ff),
      .flash_n    (loc_n),
      .on_ms      (loc_on),
      .off_ms     (loc_on),
      .pause_ms   (`SLE_PAUSE_MS),
      .led_on     (loc_lit),
      .cycle_done (loc_done)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         io_ok_led    <= 1'b0;
         io_fault_led <= 1'b0;
      end else begin
         io_ok_led    <= io_link_up && !loc_fault;
         io_fault_led <= (loc_st_ff != sle_pkg::SLE_LS_IDLE)
                         && loc_lit;
      end
   end

endmodule // sle_status_led

// >>> sle_status_led_props.sv
/*
 * Checker of the status LED blink encoder, bound to its top module.
 * Assumes one clock domain and a bind from the bench top file.
 */
`timescale 1ns/10ps

module sle_status_led_props #(
   parameter int MS_TICK_CYC = 25000
) (
   input wire logic        ref_clk,      // Clock
   input wire logic        srst,         // Reset
   input wire logic        baud_search,  // Baud search
   input wire logic        can_warn,     // Warning limit
   input wire logic [1:0]  nmt_state,    // Node state
   input wire logic        fw_pre_c0,    // Old firmware
   input wire logic [15:0] guard_ms,     // Guard time
   input wire logic [7:0]  life_factor,  // Life factor
   input wire logic [15:0] hb_cons_ms,   // Heartbeat time
   input wire logic [15:0] sync_per_ms,  // Cycle period
   input wire logic        sync_rx,      // Sync pulse
   input wire logic        io_link_up,   // Link up
   input wire logic        io_fault,     // Local fault
   input wire logic        link_break,   // Link break
   input wire logic        bad_msgs,     // Bad messages
   input wire logic        bus_err_led,  // Bus LED
   input wire logic        node_led,     // Node LED
   input wire logic        io_ok_led,    // Local ok LED
   input wire logic        force_preop,  // Forced preop
   input wire logic        pdo_stop,     // PDOs off
   input wire logic        outputs_err,  // Error outputs
   input wire logic        sdo_pdo_rej,  // SDO/PDO refused
   input wire logic        guard_err,    // Guard lost
   input wire logic        sync_err,     // Sync lost
   input wire logic        event_err     // Event expired
);
   ////////////////////////////////////////////////////////////////////////
   int   sc_ff;
   int   lim;
   logic ok;
   logic idle;

   // Cycles since the last sync or since supervision was off
   always_ff @(posedge ref_clk) begin
      if (srst || sync_rx || sync_per_ms == 16'h0000) begin
         sc_ff <= 0;
      end else begin
         sc_ff <= sc_ff + 1;
      end
   end
   assign lim  = int'(sync_per_ms) + int'(sync_per_ms) / 2;
   assign ok   = io_link_up && !io_fault && !link_break && !bad_msgs;
   assign idle = !baud_search && !can_warn && !guard_err && !sync_err
                 && !event_err;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb_d @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_bus_dark_idle: assert property (idle [*3] |-> !bus_err_led)
      else $error("bus LED lit without bus error");
   a_baud_antiphase: assert property (
      baud_search [*3] |-> node_led != bus_err_led)
      else $error("baud blink not in antiphase");
   a_guard_off: assert property (
      (guard_ms == 16'h0000 || life_factor == 8'h00)
      && hb_cons_ms == 16'h0000 |-> !$rose(guard_err))
      else $error("guard error while unsupervised");
   a_err_preop: assert property (
      guard_err || sync_err || event_err
      |-> force_preop && pdo_stop && outputs_err)
      else $error("error without preop outputs");
   a_sync_window: assert property (
      $rose(sync_err) |-> sc_ff >= (lim - 1) * MS_TICK_CYC
      && sc_ff <= (lim + 1) * MS_TICK_CYC + 3)
      else $error("sync error at wrong time");
   a_pre_c0_dark: assert property (
      (nmt_state == 2'h0 && fw_pre_c0 && !baud_search && !force_preop)
      [*3] |-> !node_led)
      else $error("node LED lit when stopped on old firmware");
   a_stop_reject: assert property (
      sdo_pdo_rej == (nmt_state == 2'h0 && !force_preop))
      else $error("SDO/PDO refusal wrong");
   a_op_node_on: assert property (
      (nmt_state == 2'h2 && !baud_search && !force_preop) [*3]
      |-> node_led)
      else $error("node LED dark while operational");
   a_ok_led_on: assert property (ok [*3] |-> io_ok_led)
      else $error("ok LED dark while local I/O good");
   a_ok_led_off: assert property (!ok [*3] |-> !io_ok_led)
      else $error("ok LED lit during local fault");

   c_guard: cover property ($rose(guard_err));
   c_sync: cover property ($rose(sync_err));
   c_event: cover property ($rose(event_err));
endmodule // sle_status_led_props

// >>> sle_led_observer.sv
/*
 * Observer of one indicator: reports each lit or dark run and its length.
 * Assumes the LED is sampled on the design clock.
 */
`timescale 1ns/10ps

module sle_led_observer (
   input  wire logic  ref_clk,     // Clock
   input  wire logic  srst,        // Reset
   input  wire logic  led,         // Watched LED
   output logic       run_v_ff,    // Run ended, pulse
   output logic       run_lvl_ff,  // Level of that run
   output logic [15:0] run_len_ff  // Its length in cycles
);
   logic        last_ff;
   logic [15:0] cnt_ff;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         last_ff  <= 1'b0;
         cnt_ff   <= 16'h0001;
         run_v_ff <= 1'b0;
      end else if (led != last_ff) begin
         run_v_ff   <= 1'b1;
         run_lvl_ff <= last_ff;
         run_len_ff <= cnt_ff;
         cnt_ff     <= 16'h0001;
         last_ff    <= led;
      end else begin
         run_v_ff <= 1'b0;
         cnt_ff   <= cnt_ff + 16'h0001;
      end
   end
endmodule // sle_led_observer

// >>> tb_sle_status_led.sv
/*
 * Self-checking bench of the status LED blink encoder.
 * Assumes a 5-cycle millisecond so that blink runs stay short.
 */
`timescale 1ns/10ps

module tb_sle_status_led;
   localparam int M = 5;
   logic ref_clk, srst, baud_search, can_warn, fw_pre_c0, guard_rx, hb_rx;
   logic sync_rx, rpdo_rx, err_clr, io_link_up, io_fault, link_break;
   logic bad_msgs, bus_err_led, node_led, io_ok_led, io_fault_led;
   logic force_preop, pdo_stop, outputs_err, sdo_pdo_rej;
   logic guard_err, sync_err, event_err;
   logic [1:0]        nmt_state;
   logic [7:0]        life_factor;
   logic [15:0]       guard_ms, hb_cons_ms, sync_per_ms, event_ms;
   logic [3:0]        io_code, io_arg, break_pos, bad_pos;
   logic [2:0]        leds, rv, rl;
   logic [2:0][15:0]  rn;
   logic [16:0]       q[3][$];
   logic [16:0]       e;
   int                errors, n_compared, k;

   assign leds = {io_fault_led, node_led, bus_err_led};

   sle_status_led #(.MS_TICK_CYC(M)) dut (.ref_clk, .srst, .baud_search,
      .can_warn, .nmt_state, .fw_pre_c0, .guard_ms, .life_factor,
      .hb_cons_ms, .sync_per_ms, .event_ms, .guard_rx, .hb_rx, .sync_rx,
      .rpdo_rx, .err_clr, .io_link_up, .io_fault, .io_code, .io_arg,
      .link_break, .break_pos, .bad_msgs, .bad_pos, .bus_err_led,
      .node_led, .io_ok_led, .io_fault_led, .force_preop, .pdo_stop,
      .outputs_err, .sdo_pdo_rej, .guard_err, .sync_err, .event_err);

   for (genvar g = 0; g < 3; g++) begin : g_obs
      sle_led_observer u_obs (.ref_clk, .srst, .led(leds[g]),
         .run_v_ff(rv[g]), .run_lvl_ff(rl[g]), .run_len_ff(rn[g]));
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(logic g, logic x);
      n_compared++;
      if (g !== x) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   // Run lengths may differ by up to 12 cycles after a restart
   task automatic chk_run(logic l, logic [15:0] n, logic [16:0] x);
      int   t;
      logic ok;
      t  = x[15:0] * M;
      ok = (l === x[16]) && (n + 12 >= t) && (n <= t + 12);
      n_compared++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, {l, n}, {x[16], t});
      end
   endtask

   task automatic grp(int i, int n, int on, int off, int ps, bit tl);
      for (int j = 0; j < n; j++) begin
         q[i].push_back({1'b1, on[15:0]});
         q[i].push_back({1'b0, (j == n - 1) ? ps[15:0] : off[15:0]});
      end
      if (tl) begin
         q[i].push_back({1'b1, on[15:0]});
      end
   endtask

   task automatic arm(int i);
      repeat (3) @(posedge ref_clk);
      wait (leds[i] === 1'b0);
      wait (leds[i] === 1'b1);
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic wq(int i);
      for (int j = 0; j < 40000 && q[i].size() > 0; j++) begin
         @(posedge ref_clk);
      end
      chk(q[i].size() == 0, 1'b1);
   endtask

   task automatic kicks();
      repeat (4) begin
         @(posedge ref_clk);
         {hb_rx, guard_rx, rpdo_rx} <= 3'h7;
         @(posedge ref_clk);
         {hb_rx, guard_rx, rpdo_rx} <= 3'h0;
         repeat (8) @(posedge ref_clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (rv[i] === 1'b1 && q[i].size() > 0) begin
            e = q[i].pop_front();
            chk_run(rl[i], rn[i], e);
         end
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial begin
      #(40 * 80000);
      errors++;
      test_done();
   end

   initial begin
      k = $urandom(32'hbc22);
      srst = 1'b1;
      {baud_search, can_warn, guard_rx, hb_rx, sync_rx, rpdo_rx} = '0;
      {err_clr, io_fault, link_break, bad_msgs} = '0;
      {guard_ms, hb_cons_ms, sync_per_ms, event_ms, life_factor} = '0;
      {fw_pre_c0, io_link_up} = 2'h3;
      nmt_state = sle_pkg::SLE_NMT_STOPPED;
      {io_code, io_arg, bad_pos} = 12'($urandom);
      break_pos = 4'($urandom_range(3, 1));
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk(bus_err_led, 1'b0);
      chk(node_led, 1'b0);
      chk(sdo_pdo_rej, 1'b1);
      chk(io_ok_led, 1'b1);
      fork
         begin
            {link_break, bad_msgs, io_fault} <= 3'h7;
            arm(2);
            // First fast flash went by in arm
            grp(2, 7, 50, 50, 1000, 0);
            grp(2, 3, 200, 200, 1000, 0);
            grp(2, break_pos, 200, 200, 1000, 0);
            grp(2, 0, 50, 0, 0, 1);
         end
      join_none
      baud_search <= 1'b1;
      arm(0);
      grp(0, 2, 50, 50, 50, 1);
      wq(0);
      chk(io_ok_led, 1'b0);
      @(posedge ref_clk);
      {baud_search, fw_pre_c0} <= 2'h0;
      can_warn <= 1'b1;
      guard_ms <= 16'h0005;
      fork
         begin
            arm(0);
            grp(0, 1, 200, 1000, 1000, 1);
         end
         begin
            arm(1);
            grp(1, 1, 200, 1000, 1000, 1);
         end
      join
      hb_cons_ms <= 16'h0003;
      kicks();
      hb_cons_ms <= 16'h0000;
      wq(0);
      wq(1);
      chk(guard_err, 1'b0);
      @(posedge ref_clk);
      life_factor <= 8'h02;
      for (k = 0; k < 300 && guard_err !== 1'b1; k++) begin
         @(posedge ref_clk);
      end
      chk(k >= 8 * M && k <= 12 * M, 1'b1);
      chk(force_preop & pdo_stop & outputs_err, 1'b1);
      fork
         begin
            arm(0);
            // Arm ends in the second flash
            grp(0, 1, 200, 200, 1000, 0);
            grp(0, 1, 200, 200, 200, 1);
         end
         begin
            arm(1);
            grp(1, 1, 200, 200, 200, 1);
         end
      join
      wq(0);
      wq(1);
      sync_per_ms <= 16'h0004;
      @(posedge ref_clk);
      sync_rx <= 1'b1;
      @(posedge ref_clk);
      sync_rx <= 1'b0;
      arm(0);
      grp(0, 3, 200, 200, 1000, 1);
      chk(sync_err, 1'b1);
      wq(0);
      event_ms <= 16'h0003;
      kicks();
      chk(event_err, 1'b0);
      arm(0);
      grp(0, 4, 200, 200, 1000, 1);
      chk(event_err & outputs_err, 1'b1);
      wq(0);
      {guard_ms, sync_per_ms, event_ms} <= '0;
      {can_warn, err_clr} <= 2'h1;
      nmt_state <= sle_pkg::SLE_NMT_OP;
      @(posedge ref_clk);
      err_clr <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk(guard_err | sync_err | event_err, 1'b0);
      chk(node_led, 1'b1);
      chk(bus_err_led, 1'b0);
      chk(sdo_pdo_rej, 1'b0);
      wq(2);
      test_done();
   end
endmodule // tb_sle_status_led

bind sle_status_led sle_status_led_props #(.MS_TICK_CYC(MS_TICK_CYC))
   u_props (.ref_clk, .srst, .baud_search, .can_warn, .nmt_state,
   .fw_pre_c0, .guard_ms, .life_factor, .hb_cons_ms, .sync_per_ms,
   .sync_rx, .io_link_up, .io_fault, .link_break, .bad_msgs, .bus_err_led,
   .node_led, .io_ok_led, .force_preop, .pdo_stop, .outputs_err,
   .sdo_pdo_rej, .guard_err, .sync_err, .event_err);
